/* File: inc/lin_mode_cfg.svh */
`ifndef LIN_MODE_CFG_SVH
`define LIN_MODE_CFG_SVH

// shared control word index per uart instance; byte address is four times the index
`define LM_IDX_CTL_UART0  12'hF43
`define LM_IDX_CTL_UART1  12'hF4B
`define LM_WORD_LSB       2

// byte addresses of the block's own registers
`define LM_ADDR_CFG       16'h0000
`define LM_ADDR_STATUS    16'h0004
`define LM_ADDR_MASK      16'h0008
`define LM_ADDR_BAUD      16'h000C
`define LM_ADDR_MODE      16'h0010

// bank-select encoding that exposes the lin control word
`define LM_BANK_LIN       3'h2

// lin control word fields
`define LM_BIT_MASTER     7
`define LM_BIT_SLAVE      6
`define LM_BIT_AB_EN      5
`define LM_BIT_AB_IEN     4
`define LM_STATE_HI       3
`define LM_STATE_LO       2
`define LM_BRK_HI         1
`define LM_BRK_LO         0

// configuration word fields
`define LM_CFG_BANK_HI    2
`define LM_CFG_BANK_LO    0
`define LM_CFG_PARITY     3
`define LM_CFG_MULTIPROCESSOR_ENABLE       4

// status and mask bits
`define LM_ST_AB_DONE     0
`define LM_ST_BREAK       1
`define LM_ST_WIDTH       2

// mode readback bits
`define LM_MODE_MASTER    0
`define LM_MODE_SLAVE     1
`define LM_MODE_AB_RUN    2

// reset values
`define LM_RST_BYTE       8'h00
`define LM_RST_BANK       3'h0
`define LM_RST_ST         2'h0
`define LM_RST_BRK        2'h0

// sync character: falling edges after the first one, bits spanned as a power of two
`define LM_SYNC_FALLS     3'h4
`define LM_SYNC_SHIFT     3

// axi responses
`define LM_RESP_OKAY      2'h0
`define LM_RESP_SLVERR    2'h2

`endif

/* File: inc/lin_mode_pkg.sv */
package lin_mode_pkg;

  // order gives 00 sleep, 01 wait for break, 10 autobaud, 11 active
  typedef enum logic [1:0]
  {
    lin_sleep,
    lin_wait_break,
    lin_autobaud,
    lin_active
  } lin_state_type;

endpackage : lin_mode_pkg

/* File: rtl/lin_autobaud_meter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lin_mode_cfg.svh"

module lin_autobaud_meter
#(
  parameter int COUNT_WIDTH = 16
)
(
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // control and synchronised line
  input  wire logic                   run,
  input  wire logic                   rx,
  // result
  output var  logic                   done,
  output var  logic [COUNT_WIDTH-1:0] bit_time
);

  logic                   rx_prev;
  logic [2:0]             falls;
  logic [COUNT_WIDTH-1:0] cycles;

  wire fall_edge = rx_prev & ~rx;
  wire last_fall = fall_edge && (falls == `LM_SYNC_FALLS);
  wire saturated = &cycles;

  generate
    if (COUNT_WIDTH <= `LM_SYNC_SHIFT)
    begin : bad_width
      $error("lin_autobaud_meter: COUNT_WIDTH too small for the sync span");
    end
  endgenerate

  // five falling edges of the sync character span eight bit times
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_prev  <= 1'b1;
      falls    <= 3'h0;
      cycles   <= '0;
      done     <= 1'b0;
      bit_time <= '0;
    end
    else
    begin
      rx_prev <= rx;
      done    <= run & last_fall;
      if (!run || last_fall)
      begin
        falls  <= 3'h0;
        cycles <= '0;
      end
      else if (fall_edge)
      begin
        falls  <= falls + 3'h1;
        cycles <= (falls == 3'h0) ? '0 : cycles + 1'b1;
      end
      else if (falls != 3'h0 && !saturated)
      begin
        cycles <= cycles + 1'b1;
      end
      if (run && last_fall)
      begin
        bit_time <= (cycles + 1'b1) >> `LM_SYNC_SHIFT;
      end
    end
  end

endmodule : lin_autobaud_meter

`default_nettype wire

/* File: rtl/lin_mode_control.sv */
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lin_mode_cfg.svh"

// What this block does
// - LIN control word appears at the shared address only while bank select is LIN.
// - master bit gives master mode only with multiprocessor, parity, slave bit clear.
// - master bit clear means the uart never acts as LIN master.
// - slave bit gives slave mode only with multiprocessor, parity, master bit clear.
// - autobaud bit starts rate detection only in slave mode; clear keeps it off.
// - autobaud interrupt bit set in slave mode: autobaud character raises receive request.
// - autobaud character reception sets the autobaud-done flag in primary status.
// - autobaud interrupt bit clear: finishing autobaud raises no interrupt request.
// - state field: sleep, wait-break, autobaud, active; middle two need slave mode.

module lin_mode_control
#(
  parameter int ADDR_WIDTH  = 16,
  parameter int COUNT_WIDTH = 16
)
(
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_WIDTH-1:0]  awaddr,
  input  wire logic                   awvalid,
  output var  logic                   awready,
  // axi4-lite write data
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output var  logic                   wready,
  // axi4-lite write response
  output var  logic [1:0]             bresp,
  output var  logic                   bvalid,
  input  wire logic                   bready,
  // axi4-lite read address
  input  wire logic [ADDR_WIDTH-1:0]  araddr,
  input  wire logic                   arvalid,
  output var  logic                   arready,
  // axi4-lite read data
  output var  logic [31:0]            rdata,
  output var  logic [1:0]             rresp,
  output var  logic                   rvalid,
  input  wire logic                   rready,
  // lin bus receive pin and receiver event
  input  wire logic                   lin_rx,
  input  wire logic                   break_seen,
  // mode and event outputs
  output var  logic                   lin_master_mode,
  output var  logic                   lin_slave_mode,
  output var  logic                   autobaud_active,
  output var  logic                   rx_irq_req,
  output var  logic                   irq,
  output var  logic [COUNT_WIDTH-1:0] autobaud_bit_time
);

  localparam logic [ADDR_WIDTH-1:0] addr_cfg    = ADDR_WIDTH'(`LM_ADDR_CFG);
  localparam logic [ADDR_WIDTH-1:0] addr_status = ADDR_WIDTH'(`LM_ADDR_STATUS);
  localparam logic [ADDR_WIDTH-1:0] addr_mask   = ADDR_WIDTH'(`LM_ADDR_MASK);
  localparam logic [ADDR_WIDTH-1:0] addr_baud   = ADDR_WIDTH'(`LM_ADDR_BAUD);
  localparam logic [ADDR_WIDTH-1:0] addr_mode   = ADDR_WIDTH'(`LM_ADDR_MODE);
  localparam logic [ADDR_WIDTH-1:0] addr_ctl    =
    ADDR_WIDTH'(`LM_IDX_CTL_UART0) << `LM_WORD_LSB;

  generate
    if (ADDR_WIDTH < 14 || ADDR_WIDTH > 32)
    begin : bad_addr
      $error("lin_mode_control: ADDR_WIDTH must lie in 14..32");
    end
    if (COUNT_WIDTH < 8 || COUNT_WIDTH > 32)
    begin : bad_count
      $error("lin_mode_control: COUNT_WIDTH must lie in 8..32");
    end
  endgenerate

  function automatic logic hits(input logic [ADDR_WIDTH-1:0] a,
                                input logic [ADDR_WIDTH-1:0] r);
    hits = (a[ADDR_WIDTH-1:`LM_WORD_LSB] == r[ADDR_WIDTH-1:`LM_WORD_LSB]);
  endfunction : hits

  function automatic logic is_mapped(input logic [ADDR_WIDTH-1:0] a);
    is_mapped = hits(a, addr_cfg) | hits(a, addr_status) | hits(a, addr_mask) |
                hits(a, addr_baud) | hits(a, addr_mode) | hits(a, addr_ctl);
  endfunction : is_mapped

  // bus holding registers
  logic                    aw_held;
  logic                    w_held;
  logic [ADDR_WIDTH-1:0]   aw_addr_q;
  logic [31:0]             w_data_q;
  logic [3:0]              w_strb_q;

  // configuration held for the rest of the uart
  logic [2:0]              bank_select_field;
  logic                    parity_enable;
  logic                    multiprocessor_enable;

  // lin control word
  logic                    lin_master_select;
  logic                    lin_slave_select;
  logic                    autobaud_enable_bit;
  logic                    autobaud_irq_enable;
  lin_mode_pkg::lin_state_type lin_state_field;
  logic [1:0]              break_length_field;

  // primary status and its mask
  logic [`LM_ST_WIDTH-1:0] primary_status_register;
  logic [`LM_ST_WIDTH-1:0] irq_mask;

  logic                    rx_sync;
  logic                    ab_done;
  logic [COUNT_WIDTH-1:0]  ab_count;

  wire aw_take   = awvalid & awready;
  wire w_take    = wvalid & wready;
  wire ar_take   = arvalid & arready;
  wire do_write  = aw_held & w_held & ~bvalid;
  wire wr_lane   = do_write & w_strb_q[0];

  // other banks own the shared address when bank select is not lin
  wire ctl_bank_lin = (bank_select_field == `LM_BANK_LIN);
  wire wr_cfg    = wr_lane & hits(aw_addr_q, addr_cfg);
  wire wr_ctl    = wr_lane & hits(aw_addr_q, addr_ctl) & ctl_bank_lin;
  wire wr_status = wr_lane & hits(aw_addr_q, addr_status);
  wire wr_mask   = wr_lane & hits(aw_addr_q, addr_mask);

  // mode qualification
  wire frame_plain = ~parity_enable & ~multiprocessor_enable;
  wire master_ok   = lin_master_select & ~lin_slave_select & frame_plain;
  wire slave_ok    = lin_slave_select & ~lin_master_select & frame_plain;
  wire in_wait     = slave_ok && (lin_state_field == lin_mode_pkg::lin_wait_break);
  wire ab_run      = slave_ok && autobaud_enable_bit &&
                     (lin_state_field == lin_mode_pkg::lin_autobaud);

  // hardware steps the slave through its states; a software write wins the cycle
  wire break_step  = in_wait & break_seen;
  lin_mode_pkg::lin_state_type hw_state;
  lin_mode_pkg::lin_state_type next_lin_state;
  assign hw_state = break_step ?
                      (autobaud_enable_bit ? lin_mode_pkg::lin_autobaud
                                           : lin_mode_pkg::lin_active) :
                    ab_done ? lin_mode_pkg::lin_active : lin_state_field;
  assign next_lin_state = wr_ctl ?
    lin_mode_pkg::lin_state_type'(w_data_q[`LM_STATE_HI:`LM_STATE_LO]) : hw_state;

  // sticky flags: a set in the clearing cycle survives
  wire [`LM_ST_WIDTH-1:0] status_set = {break_step, ab_done};
  wire [`LM_ST_WIDTH-1:0] status_clr =
    wr_status ? w_data_q[`LM_ST_WIDTH-1:0] : `LM_RST_ST;
  wire [`LM_ST_WIDTH-1:0] next_status =
    (primary_status_register & ~status_clr) | status_set;

  // the autobaud flag interrupts only while its enable stands
  wire [`LM_ST_WIDTH-1:0] irq_src = {primary_status_register[`LM_ST_BREAK],
                                     primary_status_register[`LM_ST_AB_DONE] &
                                     autobaud_irq_enable};

  // read decode
  wire [7:0] cfg_byte  = {3'h0, multiprocessor_enable, parity_enable, bank_select_field};
  wire [7:0] ctl_byte  = {lin_master_select, lin_slave_select, autobaud_enable_bit,
                          autobaud_irq_enable, lin_state_field, break_length_field};
  wire [2:0] mode_bits = {ab_run, slave_ok, master_ok};
  wire [31:0] rd_word  =
    hits(araddr, addr_cfg)    ? {24'h00_0000, cfg_byte} :
    hits(araddr, addr_ctl)    ? (ctl_bank_lin ? {24'h00_0000, ctl_byte} : 32'h0000_0000) :
    hits(araddr, addr_status) ? 32'(primary_status_register) :
    hits(araddr, addr_mask)   ? 32'(irq_mask) :
    hits(araddr, addr_baud)   ? 32'(ab_count) :
    hits(araddr, addr_mode)   ? 32'(mode_bits) : 32'h0000_0000;

  lin_pin_sync
  #(
    .WIDTH (1)
  )
  u_rx_sync
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (lin_rx),
    .sync_out (rx_sync)
  );

  lin_autobaud_meter
  #(
    .COUNT_WIDTH (COUNT_WIDTH)
  )
  u_meter
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (ab_run),
    .rx       (rx_sync),
    .done     (ab_done),
    .bit_time (ab_count)
  );

  // write channels: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready  <= 1'b0;
      wready   <= 1'b0;
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= `LM_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
        awready   <= 1'b0;
      end
      else if (!aw_held && !bvalid)
      begin
        awready <= 1'b1;
      end
      if (w_take)
      begin
        w_held   <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        wready   <= 1'b0;
      end
      else if (!w_held && !bvalid)
      begin
        wready <= 1'b1;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= is_mapped(aw_addr_q) ? `LM_RESP_OKAY : `LM_RESP_SLVERR;
      end
      else if (bvalid && bready)
      begin
        bvalid <= 1'b0;
      end
    end
  end

  // read channel answers the cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `LM_RESP_OKAY;
    end
    else
    begin
      if (ar_take)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_word;
        rresp   <= is_mapped(araddr) ? `LM_RESP_OKAY : `LM_RESP_SLVERR;
      end
      else if (rvalid && rready)
      begin
        rvalid <= 1'b0;
      end
      else if (!rvalid)
      begin
        arready <= 1'b1;
      end
    end
  end

  // configuration and lin control word
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bank_select_field     <= `LM_RST_BANK;
      parity_enable         <= 1'b0;
      multiprocessor_enable <= 1'b0;
      lin_master_select     <= 1'b0;
      lin_slave_select      <= 1'b0;
      autobaud_enable_bit   <= 1'b0;
      autobaud_irq_enable   <= 1'b0;
      lin_state_field       <= lin_mode_pkg::lin_sleep;
      break_length_field    <= `LM_RST_BRK;
    end
    else
    begin
      if (wr_cfg)
      begin
        bank_select_field     <= w_data_q[`LM_CFG_BANK_HI:`LM_CFG_BANK_LO];
        parity_enable         <= w_data_q[`LM_CFG_PARITY];
        multiprocessor_enable <= w_data_q[`LM_CFG_MULTIPROCESSOR_ENABLE];
      end
      if (wr_ctl)
      begin
        lin_master_select   <= w_data_q[`LM_BIT_MASTER];
        lin_slave_select    <= w_data_q[`LM_BIT_SLAVE];
        autobaud_enable_bit <= w_data_q[`LM_BIT_AB_EN];
        autobaud_irq_enable <= w_data_q[`LM_BIT_AB_IEN];
        break_length_field  <= w_data_q[`LM_BRK_HI:`LM_BRK_LO];
      end
      lin_state_field <= next_lin_state;
    end
  end

  // status, mask and registered outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      primary_status_register <= `LM_RST_ST;
      irq_mask                <= `LM_RST_ST;
      lin_master_mode         <= 1'b0;
      lin_slave_mode          <= 1'b0;
      autobaud_active         <= 1'b0;
      rx_irq_req              <= 1'b0;
      irq                     <= 1'b0;
      autobaud_bit_time       <= '0;
    end
    else
    begin
      primary_status_register <= next_status;
      if (wr_mask)
      begin
        irq_mask <= w_data_q[`LM_ST_WIDTH-1:0];
      end
      lin_master_mode <= master_ok;
      lin_slave_mode  <= slave_ok;
      autobaud_active <= ab_run;
      rx_irq_req      <= ab_done & autobaud_irq_enable;
      irq             <= |(irq_src & irq_mask);
      if (ab_done)
      begin
        autobaud_bit_time <= ab_count;
      end
    end
  end

endmodule : lin_mode_control

`default_nettype wire

/* File: rtl/lin_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module lin_pin_sync
#(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // pin side and clocked side
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  generate
    if (WIDTH < 1)
    begin : bad_width
      $error("lin_pin_sync: WIDTH must be at least 1");
    end
  endgenerate

  // stage_one feeds only the second flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage_one <= '1;
      sync_out  <= '1;
    end
    else
    begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule : lin_pin_sync

`default_nettype wire

/* File: tb/lin_mode_control_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module lin_mode_control_assertions
#(
  parameter int COUNT_WIDTH = 16
)
(
  // clock and reset
  input wire logic                   aclk,
  input wire logic                   aresetn,
  // register bus handshakes
  input wire logic                   awvalid,
  input wire logic                   awready,
  input wire logic                   wvalid,
  input wire logic                   wready,
  input wire logic [1:0]             bresp,
  input wire logic                   bvalid,
  input wire logic                   bready,
  input wire logic [31:0]            rdata,
  input wire logic                   rvalid,
  input wire logic                   rready,
  // mode and event outputs
  input wire logic                   lin_master_mode,
  input wire logic                   lin_slave_mode,
  input wire logic                   autobaud_active,
  input wire logic                   rx_irq_req,
  input wire logic [COUNT_WIDTH-1:0] autobaud_bit_time
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_one_mode;
    !(lin_master_mode && lin_slave_mode);
  endproperty
  a_one_mode: assert property (p_one_mode)
    else $error("both lin modes on");
  property p_ab_slave;
    autobaud_active |-> lin_slave_mode;
  endproperty
  a_ab_slave: assert property (p_ab_slave)
    else $error("autobaud outside slave mode");
  property p_irq_pulse;
    rx_irq_req |=> !rx_irq_req;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("receive request longer than one cycle");
  property p_irq_cause;
    rx_irq_req |-> $past(autobaud_active);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("receive request without autobaud");
  property p_time_load;
    $changed(autobaud_bit_time) |-> $past(autobaud_active);
  endproperty
  a_time_load: assert property (p_time_load)
    else $error("bit time changed outside autobaud");
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data dropped");
  property p_wlat;
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_wlat: assert property (p_wlat)
    else $error("write response late");
endmodule : lin_mode_control_assertions

bind lin_mode_control lin_mode_control_assertions #(.COUNT_WIDTH(COUNT_WIDTH)) u_chk
(
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .rdata(rdata), .rvalid(rvalid), .rready(rready), .lin_master_mode(lin_master_mode),
  .lin_slave_mode(lin_slave_mode), .autobaud_active(autobaud_active),
  .rx_irq_req(rx_irq_req), .autobaud_bit_time(autobaud_bit_time)
);

`default_nettype wire

/* File: tb/lin_node_model.sv */
`timescale 1ns/1ps
`default_nettype none

module lin_node_model
(
  // clock and bus line
  input  wire logic aclk,
  output var  logic lin_tx
);
  // a released wire sits recessive high through its pull-up
  initial lin_tx = 1'b1;

  // start, 0x55 lsb first, stop: five falls spaced by two bit times
  task automatic send_sync(input int bit_cycles);
    logic [9:0] frame;
    frame = {1'b1, 8'h55, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      lin_tx <= frame[i];
      repeat (bit_cycles) @(posedge aclk);
    end
  endtask : send_sync
endmodule : lin_node_model

`default_nettype wire

/* File: tb/tb_lin_mode_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lin_mode_cfg.svh"

module tb_lin_mode_control;
  localparam logic [15:0] ctl_addr  = {2'b00, `LM_IDX_CTL_UART0, 2'b00};
  localparam logic [15:0] ctl1_addr = {2'b00, `LM_IDX_CTL_UART1, 2'b00};
  localparam logic [1:0]  rok       = `LM_RESP_OKAY;
  localparam logic [1:0]  rerr      = `LM_RESP_SLVERR;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [15:0] awaddr = 16'h0000;
  logic [15:0] araddr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        break_seen = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, lin_rx, irq;
  logic        lin_master_mode, lin_slave_mode, autobaud_active, rx_irq_req;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] autobaud_bit_time;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          irq_count = 0;

  lin_mode_control u_dut
  (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .lin_rx(lin_rx),
    .break_seen(break_seen), .lin_master_mode(lin_master_mode),
    .lin_slave_mode(lin_slave_mode), .autobaud_active(autobaud_active),
    .rx_irq_req(rx_irq_req), .irq(irq), .autobaud_bit_time(autobaud_bit_time)
  );

  lin_node_model u_node
  (
    .aclk(aclk),
    .lin_tx(lin_rx)
  );

  initial
  begin
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    if (rx_irq_req === 1'b1) irq_count++;
  end

  task automatic stop_test;
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_word

  // pending flags track each channel, since valid read back here still shows the old value
  task automatic axi_write(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_pend;
    logic w_pend;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_pend || w_pend)
    begin
      @(posedge aclk);
      if (aw_pend && awready === 1'b1)
      begin
        awvalid <= 1'b0;
        aw_pend = 1'b0;
      end
      if (w_pend && wready === 1'b1)
      begin
        wvalid <= 1'b0;
        w_pend = 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check_word({30'h0000_0000, bresp}, {30'h0000_0000, er});
  endtask : axi_write

  task automatic axi_read(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check_word(rdata, {24'h00_0000, e});
    check_word({30'h0000_0000, rresp}, {30'h0000_0000, er});
  endtask : axi_read

  // mode pins are registered, so they are looked at only after the mode read
  task automatic try_mode(input logic [7:0] cfg, input logic [7:0] ctl, input logic [1:0] em);
    axi_write(`LM_ADDR_CFG, cfg, rok);
    axi_write(ctl_addr, ctl, rok);
    axi_read(`LM_ADDR_MODE, {6'h00, em}, rok);
    check_word({30'h0000_0000, lin_slave_mode, lin_master_mode}, {30'h0000_0000, em});
  endtask : try_mode

  task automatic pulse_break;
    @(posedge aclk);
    break_seen <= 1'b1;
    @(posedge aclk);
    break_seen <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : pulse_break

  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    stop_test;
  end

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(`LM_ADDR_CFG, 8'h00, rok);
    axi_write(ctl_addr, 8'h80, rok);
    axi_write(`LM_ADDR_CFG, 8'h02, rok);
    axi_read(ctl_addr, 8'h00, rok);
    axi_read(ctl1_addr, 8'h00, rerr);
    axi_write(16'h0020, 8'h01, rerr);
    try_mode(8'h02, 8'h80, 2'b01);
    try_mode(8'h02, 8'h00, 2'b00);
    try_mode(8'h02, 8'h40, 2'b10);
    try_mode(8'h01, 8'h80, 2'b10);
    try_mode(8'h02, 8'hC0, 2'b00);
    try_mode(8'h0A, 8'h80, 2'b00);
    try_mode(8'h12, 8'h40, 2'b00);
    try_mode(8'h02, 8'h84, 2'b01);
    pulse_break;
    check_word(autobaud_active, 0);
    axi_read(ctl_addr, 8'h84, rok);
    axi_read(`LM_ADDR_STATUS, 8'h00, rok);
    axi_write(`LM_ADDR_MASK, 8'h01, rok);
    try_mode(8'h02, 8'h74, 2'b10);
    pulse_break;
    check_word(autobaud_active, 1);
    axi_read(ctl_addr, 8'h78, rok);
    u_node.send_sync(16);
    check_word(irq_count, 1);
    check_word(autobaud_bit_time, 16);
    axi_read(`LM_ADDR_STATUS, 8'h03, rok);
    check_word(irq, 1);
    axi_read(ctl_addr, 8'h7C, rok);
    axi_write(`LM_ADDR_STATUS, 8'h03, rok);
    axi_read(`LM_ADDR_STATUS, 8'h00, rok);
    check_word(irq, 0);
    try_mode(8'h02, 8'h64, 2'b10);
    pulse_break;
    u_node.send_sync(24);
    check_word(irq_count, 1);
    check_word(autobaud_bit_time, 24);
    axi_read(`LM_ADDR_STATUS, 8'h03, rok);
    check_word(irq, 0);
    axi_write(`LM_ADDR_MASK, 8'h03, rok);
    axi_read(`LM_ADDR_MASK, 8'h03, rok);
    check_word(irq, 1);
    axi_write(`LM_ADDR_STATUS, 8'h03, rok);
    try_mode(8'h02, 8'h44, 2'b10);
    pulse_break;
    check_word(autobaud_active, 0);
    u_node.send_sync(16);
    check_word(irq_count, 1);
    check_word(autobaud_bit_time, 24);
    axi_read(ctl_addr, 8'h4C, rok);
    stop_test;
  end
endmodule : tb_lin_mode_control

`default_nettype wire
